// ===== src/rotret_pkg.sv
// What this block does
// - Left rotate (opcode 00_1101) shifts file register left through carry, one cycle.
// - Destination bit 0 writes working register; 1 writes the file register back.
// - Instruction holds 7-bit file address and destination bit in its low bits.
// - Literal return: decode, read literal, idle, then write W and pop in phase four.
// - Literal return reloads program counter from top stack entry, literal into W.
// - Returns take two cycles; second cycle is idle while the pipeline refills.
package rotret_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PCNT_W = 13;
	localparam int DEST_BIT = 7;
	localparam int OP_HI = 13;
	localparam int OP_LO = 8;
	localparam logic [5:0] ROT_LEFT_CODE = 6'h0D;
	localparam logic [5:0] ROT_RIGHT_CODE = 6'h0C;
	localparam logic [3:0] LIT_RET_CODE = 4'hD;
	localparam int RET_OP_HI = 13;
	localparam int RET_OP_LO = 10;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;

	typedef enum {ST_EXEC, ST_FLUSH} exec_state_e;

	typedef struct packed {
		logic wr_w;
		logic wr_f;
		logic [FADDR_W-1:0] faddr;
		logic [DATA_W-1:0] data;
		logic wr_c;
		logic carry;
	} wb_s;

	typedef struct packed {
		logic pop;
		logic load;
		logic [PCNT_W-1:0] target;
	} jump_s;
endpackage : rotret_pkg

// ===== src/rotate_and_return_exec.sv
`timescale 1ns/1ps
module rotate_and_return_exec
	import rotret_pkg::*;
(
	// Clock, reset and enable.
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CE,
	// Instruction phase and word.
	input wire logic [1:0] PHASE,
	input wire logic [INSN_W-1:0] INSN,
	// Operands from the core.
	input wire logic [DATA_W-1:0] FILE_RDATA,
	input wire logic CARRY_IN,
	input wire logic [PCNT_W-1:0] TOP_STACK_ENTRY,
	// Results.
	output wb_s WB,
	output jump_s PCU,
	output logic BUSY,
	output logic [FADDR_W-1:0] FILE_RADDR
);

	// Decoded fields of the latched word.
	logic [OP_HI-OP_LO:0] op_field;
	logic [RET_OP_HI-RET_OP_LO:0] ret_field;
	logic is_rot_left;
	logic is_rot_right;
	logic is_rot;
	logic is_lit_ret;
	logic dest_is_file;
	logic [FADDR_W-1:0] faddr_field;
	logic [DATA_W-1:0] lit_field;

	// Phase strobes.
	logic in_exec;
	logic take_q1;
	logic take_q2;
	logic take_q4;
	logic flush_q4;

	// Rotate datapath.
	logic [DATA_W-1:0] rot_data;
	logic rot_carry;

	// State and result registers.
	exec_state_e state_reg;
	exec_state_e state_next;
	logic [INSN_W-1:0] insn_reg;
	logic [DATA_W-1:0] opnd_reg;
	logic [DATA_W-1:0] lit_reg;
	logic wr_w_reg;
	logic wr_f_reg;
	logic wr_c_reg;
	logic [FADDR_W-1:0] faddr_reg;
	logic [DATA_W-1:0] data_reg;
	logic carry_reg;
	logic pop_reg;
	logic load_reg;
	logic [PCNT_W-1:0] target_reg;

	assign op_field = insn_reg[OP_HI:OP_LO];
	assign ret_field = insn_reg[RET_OP_HI:RET_OP_LO];
	assign is_rot_left = (op_field == ROT_LEFT_CODE);
	assign is_rot_right = (op_field == ROT_RIGHT_CODE);
	assign is_rot = is_rot_left || is_rot_right;
	// The top four bits must match exactly, or the literal move would pop the stack too.
	assign is_lit_ret = (ret_field == LIT_RET_CODE);
	assign dest_is_file = insn_reg[DEST_BIT];
	assign faddr_field = insn_reg[FADDR_W-1:0];
	assign lit_field = insn_reg[DATA_W-1:0];

	// The flush cycle ignores its word, so the take strobes below wait for the execute state; flush_q4 fires only in the flush state.
	assign in_exec = (state_reg == ST_EXEC);
	assign take_q1 = CE && (PHASE == PH_Q1) && in_exec;
	assign take_q2 = CE && (PHASE == PH_Q2) && in_exec;
	assign take_q4 = CE && (PHASE == PH_Q4) && in_exec;
	assign flush_q4 = CE && (PHASE == PH_Q4) && !in_exec;

	always_comb begin
		rot_data = '0;
		rot_carry = 1'b0;
		if (is_rot_left) begin
			rot_data = {opnd_reg[DATA_W-2:0], CARRY_IN};
			rot_carry = opnd_reg[DATA_W-1];
		end else if (is_rot_right) begin
			rot_data = {CARRY_IN, opnd_reg[DATA_W-1:1]};
			rot_carry = opnd_reg[0];
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				if (take_q4 && is_lit_ret) begin
					state_next = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				if (flush_q4) begin
					state_next = ST_EXEC;
				end
			end
			default: begin
				state_next = ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state_reg <= ST_EXEC;
		end else if (CE) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			insn_reg <= '0;
		end else if (take_q1) begin
			insn_reg <= INSN;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			opnd_reg <= '0;
		end else if (take_q2) begin
			opnd_reg <= FILE_RDATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			lit_reg <= '0;
		end else if (take_q2) begin
			lit_reg <= lit_field;
		end
	end

	// Write strobes are one-clock pulses launched by the Q4 edge.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			wr_w_reg <= 1'b0;
		end else if (CE) begin
			wr_w_reg <= take_q4 && ((is_rot && !dest_is_file) || is_lit_ret);
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			wr_f_reg <= 1'b0;
		end else if (CE) begin
			wr_f_reg <= take_q4 && is_rot && dest_is_file;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			wr_c_reg <= 1'b0;
		end else if (CE) begin
			wr_c_reg <= take_q4 && is_rot;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			faddr_reg <= '0;
		end else if (take_q4 && is_rot) begin
			faddr_reg <= faddr_field;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			data_reg <= '0;
		end else if (take_q4) begin
			if (is_rot) begin
				data_reg <= rot_data;
			end else if (is_lit_ret) begin
				data_reg <= lit_reg;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			carry_reg <= 1'b0;
		end else if (take_q4 && is_rot) begin
			carry_reg <= rot_carry;
		end
	end

	// The stack pop and the counter reload pulse in the first clock of the idle second cycle, launched by the Q4 edge.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pop_reg <= 1'b0;
		end else if (CE) begin
			pop_reg <= take_q4 && is_lit_ret;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			load_reg <= 1'b0;
		end else if (CE) begin
			load_reg <= take_q4 && is_lit_ret;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			target_reg <= '0;
		end else if (take_q4 && is_lit_ret) begin
			target_reg <= TOP_STACK_ENTRY;
		end
	end

	assign WB.wr_w = wr_w_reg;
	assign WB.wr_f = wr_f_reg;
	assign WB.faddr = faddr_reg;
	assign WB.data = data_reg;
	assign WB.wr_c = wr_c_reg;
	assign WB.carry = carry_reg;
	assign PCU.pop = pop_reg;
	assign PCU.load = load_reg;
	assign PCU.target = target_reg;
	assign BUSY = (state_reg == ST_FLUSH);
	assign FILE_RADDR = faddr_field;

endmodule : rotate_and_return_exec

// ===== sim/rotret_sva.sv
`timescale 1ns/1ps
module rotret_sva
	import rotret_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [1:0] PHASE,
	input wire logic [INSN_W-1:0] INSN,
	input wire logic [DATA_W-1:0] FILE_RDATA,
	input wire logic CARRY_IN,
	input wire logic [PCNT_W-1:0] TOP_STACK_ENTRY,
	input wb_s WB,
	input jump_s PCU,
	input wire logic BUSY,
	input wire logic [FADDR_W-1:0] FILE_RADDR
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	property p_l; WB.wr_c && $past(INSN[13:8], 4) == ROT_LEFT_CODE |->
		{WB.carry, WB.data} == {$past(FILE_RDATA, 3), $past(CARRY_IN)}; endproperty
	a_l: assert property (p_l) else $error("left rotate result");
	property p_r; WB.wr_c && $past(INSN[13:8], 4) == ROT_RIGHT_CODE |->
		{WB.data, WB.carry} == {$past(CARRY_IN), $past(FILE_RDATA, 3)}; endproperty
	a_r: assert property (p_r) else $error("right rotate result");
	property p_d; WB.wr_c |-> $past(PHASE) == 2'h3 && WB.wr_w != WB.wr_f &&
		WB.wr_f == $past(INSN[DEST_BIT], 4); endproperty
	a_d: assert property (p_d) else $error("rotate destination");
	property p_a; $past(PHASE == 2'h0 && !BUSY) |-> FILE_RADDR == $past(INSN[6:0]); endproperty
	a_a: assert property (p_a) else $error("file address");
	property p_w; PCU.pop |-> PCU.load && PCU.target == $past(TOP_STACK_ENTRY) &&
		WB.wr_w && WB.data == $past(INSN[7:0], 4); endproperty
	a_w: assert property (p_w) else $error("literal return");
	property p_b; PCU.pop |-> BUSY[*4]; endproperty
	a_b: assert property (p_b) else $error("idle second cycle");
endmodule : rotret_sva
bind rotate_and_return_exec rotret_sva u_sva (.*);

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb import rotret_pkg::*;;
	logic CLK_SYS = 0, RST = 1, CE = 1, CARRY_IN = 1;
	logic [1:0] PHASE = 0;
	logic [INSN_W-1:0] INSN = 0;
	logic [DATA_W-1:0] FILE_RDATA = 8'hA6;
	logic [PCNT_W-1:0] TOP_STACK_ENTRY = 13'h1A5C;
	wb_s WB;
	jump_s PCU;
	logic BUSY;
	logic [FADDR_W-1:0] FILE_RADDR;
	int mismatches = 0, tests_run = 0;
	rotate_and_return_exec dut (.*);
	always #25 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) PHASE <= RST ? 2'h3 : PHASE + 2'h1;
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task results;
		$display("%0d tests, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// Presents the word with Q1 and returns just after the result pulse lands.
	task run(input logic [INSN_W-1:0] i);
		@(posedge CLK_SYS iff PHASE == 2'h3);
		INSN <= i;
		repeat (4) @(posedge CLK_SYS);
		#1;
	endtask : run
	task t_rot;
		for (int d = 0; d < 2; d++) begin
			run({ROT_LEFT_CODE, d[0], 7'h55});
			chk({WB.wr_c, WB.wr_f, WB.wr_w, WB.faddr, WB.carry, WB.data},
				{1'b1, d[0], !d[0], 7'h55, 9'h14D});
			run({ROT_RIGHT_CODE, d[0], 7'h2A});
			chk({WB.wr_c, WB.wr_f, WB.wr_w, WB.faddr, WB.carry, WB.data},
				{1'b1, d[0], !d[0], 7'h2A, 9'h0D3});
		end
		$display("rotate test done");
	endtask : t_rot
	task t_ret;
		run({LIT_RET_CODE, 2'h3, 8'h7E});
		chk({BUSY, PCU.pop, PCU.load, PCU.target, WB.wr_w, WB.wr_c, WB.data},
			{3'h7, 13'h1A5C, 2'h2, 8'h7E});
		$display("return test done");
	endtask : t_ret
	// A rotate offered in the idle cycle after a return must be ignored.
	task t_refuse;
		@(posedge CLK_SYS iff PHASE == 2'h3);
		INSN <= {LIT_RET_CODE, 2'h0, 8'h11};
		repeat (4) @(posedge CLK_SYS);
		INSN <= {ROT_LEFT_CODE, 1'b1, 7'h33};
		repeat (4) @(posedge CLK_SYS);
		#1;
		chk({WB.wr_c, WB.wr_f, WB.wr_w, PCU.pop, BUSY}, 5'h00);
		$display("refuse test done");
	endtask : t_refuse
	// Neighbouring literal opcode 11_00xx and an unused word give no pulses.
	task t_other;
		run({4'hC, 2'h0, 8'h33});
		chk({PCU.pop, PCU.load, BUSY, WB.wr_w, WB.wr_c}, 5'h00);
		run(14'h0000);
		chk({PCU.pop, PCU.load, BUSY, WB.wr_w, WB.wr_c, WB.wr_f}, 6'h00);
		$display("other opcode test done");
	endtask : t_other
	initial begin
		repeat (6) @(posedge CLK_SYS);
		RST <= 0;
		t_rot;
		t_ret;
		t_refuse;
		t_other;
		results;
	end
	initial begin
		#20000;
		mismatches++;
		results;
	end
endmodule : tb
